// File: rtl/nsf_device.sv
// Receiver end: sentence scheduler, framer and input checker
// What this block does
// - Sentences out on TX, input on RX
// - 9600 baud, 8 data, 1 stop, no parity
// - Six sentence types each once a second
// - Date/time sentence off until enabled
// - Dollar start, CR LF end
// - Single comma between fields
// - Asterisk then two hex checksum digits
// - Checksum is XOR between dollar and asterisk
// - Empty output fields keep their commas
// - Input with empty field is discarded
// - Host splits sentences and verifies checksum
// - Host sends complete sentence with checksum
// - Four satellites per view sentence, repeat
// - Talker prefix follows positioning system
// - Minimum sentence GP until 3D fix
// - Fix-data fields in documented order
// - Fix indicator 3, 4 or 5 sent as 0
// - Correction age empty without differential
`timescale 1ns/1ps
module nsf_device import nsf_pkg::*; #(
  parameter int SEC_PER = SEC_CYC,
  parameter int BIT_PER = BIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  nsf_if.dev lnk,
  input wire logic combined,
  input wire logic fix3d,
  input wire logic dgps_used,
  input wire logic [5:0] gp_sv_cnt,
  input wire logic [5:0] gl_sv_cnt,
  input wire logic zda_on,
  input wire logic zda_off,
  output logic [2:0] pl_msg,
  output logic [4:0] pl_part,
  output logic pl_gl,
  input wire logic [7:0] pl_data,
  input wire logic pl_valid,
  input wire logic pl_last,
  output logic pl_ready,
  output logic [7:0] in_data,
  output logic in_valid,
  output logic in_ok,
  output logic in_drop
);

  typedef struct packed {
    logic [24:0] sec;
    nsf_tx_st_t st;
    logic [2:0] idx;
    nsf_msg_t msg;
    nsf_tk_t tk;
    logic [4:0] part;
    logic gl_pass;
    logic [7:0] sum;
    logic [3:0] fld;
    logic zda_en;
  } nsf_dev_st_t;

  nsf_dev_st_t st_r, st_nxt;
  logic tx_v;
  logic tx_ready;
  logic [7:0] tx_ch;
  logic skip;
  logic [7:0] pch;
  logic [5:0] sel_cnt;
  logic [6:0] cnt7;
  logic [4:0] parts;
  logic [15:0] tkc;
  logic [23:0] idc;

  // ****************************************************************
  // Talker selection
  // ****************************************************************
  function automatic nsf_tk_t tk_of(input nsf_msg_t m, input logic cmb,
                                    input logic f3);
    tk_of = TK_GP;
    if (cmb && (m == MSG_GLL || m == MSG_GSA)) tk_of = TK_GN;
    if (cmb && f3 && m == MSG_RMC) tk_of = TK_GN;
  endfunction

  function automatic logic [15:0] tk_chars(input nsf_tk_t t);
    unique case (t)
      TK_GP: return TALK_GP;
      TK_GN: return TALK_GN;
      default: return TALK_GL;
    endcase
  endfunction

  // ****************************************************************
  // Serial link and input checker
  // ****************************************************************
  nsf_link #(.REJECT_EMPTY(1'b1), .BIT_PER(BIT_PER)) u_link (
    .clk(clk),
    .nrst(nrst),
    .tx_data(tx_ch),
    .tx_valid(tx_v),
    .tx_ready(tx_ready),
    .txd(lnk.dev_txd),
    .rxd(lnk.host_txd),
    .rx_data(in_data),
    .rx_valid(in_valid),
    .rx_ok(in_ok),
    .rx_drop(in_drop)
  );

  // ****************************************************************
  // Sentence scheduler and framer
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    tx_v = 1'b0;
    tx_ch = CH_DOLLAR;
    pl_ready = 1'b0;
    skip = 1'b0;
    pch = pl_data;
    sel_cnt = st_r.gl_pass ? gl_sv_cnt : gp_sv_cnt;
    cnt7 = {1'b0, sel_cnt} + SV_ROUND;
    parts = (cnt7[6:2] == 5'h00) ? 5'h01 : cnt7[6:2];
    tkc = tk_chars(st_r.tk);
    idc = nsf_msg_id(st_r.msg);
    if (zda_on) st_nxt.zda_en = 1'b1;
    else if (zda_off) st_nxt.zda_en = 1'b0;
    if (st_r.sec == 25'h0000000) st_nxt.sec = 25'(SEC_PER - 1);
    else st_nxt.sec = st_r.sec - 25'h0000001;
    if (st_r.msg == MSG_GGA && st_r.fld == GGA_FIX_FLD &&
        pl_data >= CH_3 && pl_data <= CH_5) begin
      pch = FIX_NONE;
    end
    if (st_r.msg == MSG_GGA && st_r.fld == GGA_AGE_FLD && !dgps_used &&
        pl_data != CH_COMMA) begin
      skip = 1'b1;
    end
    unique case (st_r.st)
      T_IDLE: begin
        if (st_r.sec == 25'h0000000) begin
          st_nxt.st = T_HEAD;
          st_nxt.idx = 3'h0;
          st_nxt.msg = MSG_GGA;
          st_nxt.tk = TK_GP;
          st_nxt.part = 5'h00;
          st_nxt.gl_pass = 1'b0;
        end
      end
      T_HEAD: begin
        tx_v = 1'b1;
        case (st_r.idx)
          3'h0: tx_ch = CH_DOLLAR;
          3'h1: tx_ch = tkc[15:8];
          3'h2: tx_ch = tkc[7:0];
          3'h3: tx_ch = idc[23:16];
          3'h4: tx_ch = idc[15:8];
          3'h5: tx_ch = idc[7:0];
          default: tx_ch = CH_COMMA;
        endcase
        if (tx_ready) begin
          st_nxt.sum = (st_r.idx == 3'h0) ? 8'h00 : st_r.sum ^ tx_ch;
          st_nxt.idx = st_r.idx + 3'h1;
          if (st_r.idx == HEAD_LAST) begin
            st_nxt.st = T_PAY;
            st_nxt.fld = 4'h1;
          end
        end
      end
      T_PAY: begin
        pl_ready = tx_ready;
        tx_v = pl_valid & ~skip;
        tx_ch = pch;
        if (pl_valid && tx_ready) begin
          if (!skip) st_nxt.sum = st_r.sum ^ pch;
          if (pl_data == CH_COMMA) st_nxt.fld = st_r.fld + 4'h1;
          if (pl_last) st_nxt.st = T_STAR;
        end
      end
      T_STAR: begin
        tx_v = 1'b1;
        tx_ch = CH_STAR;
        if (tx_ready) st_nxt.st = T_HEX1;
      end
      T_HEX1: begin
        tx_v = 1'b1;
        tx_ch = nsf_hex_char(st_r.sum[7:4]);
        if (tx_ready) st_nxt.st = T_HEX0;
      end
      T_HEX0: begin
        tx_v = 1'b1;
        tx_ch = nsf_hex_char(st_r.sum[3:0]);
        if (tx_ready) st_nxt.st = T_CR;
      end
      T_CR: begin
        tx_v = 1'b1;
        tx_ch = CH_CR;
        if (tx_ready) st_nxt.st = T_LF;
      end
      T_LF: begin
        tx_v = 1'b1;
        tx_ch = CH_LF;
        if (tx_ready) st_nxt.st = T_NEXT;
      end
      T_NEXT: begin
        st_nxt.st = T_HEAD;
        st_nxt.idx = 3'h0;
        if (st_r.msg == MSG_GSV && (st_r.part + 5'h01) < parts) begin
          st_nxt.part = st_r.part + 5'h01;
        end else if (st_r.msg == MSG_GSV && !st_r.gl_pass && combined) begin
          st_nxt.gl_pass = 1'b1;
          st_nxt.part = 5'h00;
          st_nxt.tk = TK_GL;
        end else begin
          st_nxt.part = 5'h00;
          st_nxt.gl_pass = 1'b0;
          unique case (st_r.msg)
            MSG_GGA: st_nxt.msg = MSG_GLL;
            MSG_GLL: st_nxt.msg = MSG_GSA;
            MSG_GSA: st_nxt.msg = MSG_GSV;
            MSG_GSV: st_nxt.msg = MSG_RMC;
            MSG_RMC: st_nxt.msg = MSG_VTG;
            MSG_VTG: begin
              if (st_r.zda_en) st_nxt.msg = MSG_ZDA;
              else st_nxt.st = T_IDLE;
            end
            default: st_nxt.st = T_IDLE;
          endcase
          st_nxt.tk = tk_of(st_nxt.msg, combined, fix3d);
        end
      end
      default: st_nxt.st = T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pl_msg = st_r.msg;
  assign pl_part = st_r.part;
  assign pl_gl = st_r.gl_pass;

endmodule

// File: rtl/nsf_host.sv
// Host end: input sentence framer and output sentence checker
`timescale 1ns/1ps
module nsf_host import nsf_pkg::*; #(
  parameter int BIT_PER = BIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  nsf_if.host lnk,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  output logic out_ok,
  output logic out_drop
);

  typedef struct packed {
    nsf_tx_st_t st;
    logic [7:0] sum;
  } nsf_host_st_t;

  nsf_host_st_t st_r, st_nxt;
  logic tx_v;
  logic tx_ready;
  logic [7:0] tx_ch;

  // ****************************************************************
  // Serial link and output checker
  // ****************************************************************
  nsf_link #(.REJECT_EMPTY(1'b0), .BIT_PER(BIT_PER)) u_link (
    .clk(clk),
    .nrst(nrst),
    .tx_data(tx_ch),
    .tx_valid(tx_v),
    .tx_ready(tx_ready),
    .txd(lnk.host_txd),
    .rxd(lnk.dev_txd),
    .rx_data(out_data),
    .rx_valid(out_valid),
    .rx_ok(out_ok),
    .rx_drop(out_drop)
  );

  // ****************************************************************
  // Input sentence framer
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    tx_v = 1'b0;
    tx_ch = CH_DOLLAR;
    cmd_ready = 1'b0;
    unique case (st_r.st)
      T_IDLE: if (cmd_valid) st_nxt.st = T_HEAD;
      T_HEAD: begin
        tx_v = 1'b1;
        tx_ch = CH_DOLLAR;
        if (tx_ready) begin
          st_nxt.sum = 8'h00;
          st_nxt.st = T_PAY;
        end
      end
      T_PAY: begin
        cmd_ready = tx_ready;
        tx_v = cmd_valid;
        tx_ch = cmd_data;
        if (cmd_valid && tx_ready) begin
          st_nxt.sum = st_r.sum ^ cmd_data;
          if (cmd_last) st_nxt.st = T_STAR;
        end
      end
      T_STAR: begin
        tx_v = 1'b1;
        tx_ch = CH_STAR;
        if (tx_ready) st_nxt.st = T_HEX1;
      end
      T_HEX1: begin
        tx_v = 1'b1;
        tx_ch = nsf_hex_char(st_r.sum[7:4]);
        if (tx_ready) st_nxt.st = T_HEX0;
      end
      T_HEX0: begin
        tx_v = 1'b1;
        tx_ch = nsf_hex_char(st_r.sum[3:0]);
        if (tx_ready) st_nxt.st = T_CR;
      end
      T_CR: begin
        tx_v = 1'b1;
        tx_ch = CH_CR;
        if (tx_ready) st_nxt.st = T_LF;
      end
      T_LF: begin
        tx_v = 1'b1;
        tx_ch = CH_LF;
        if (tx_ready) st_nxt.st = T_IDLE;
      end
      default: st_nxt.st = T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: rtl/nsf_if.sv
// Serial lines joining the receiver end and the host end
`timescale 1ns/1ps
interface nsf_if;
  logic dev_txd;
  logic host_txd;
  modport dev (output dev_txd, input host_txd);
  modport host (input dev_txd, output host_txd);
endinterface

// File: rtl/nsf_link.sv
// Character serialiser, deserialiser and sentence checker
`timescale 1ns/1ps
module nsf_link import nsf_pkg::*; #(
  parameter bit REJECT_EMPTY = 1'b0,
  parameter int BIT_PER = BIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic txd,
  input wire logic rxd,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_ok,
  output logic rx_drop
);

  typedef struct packed {
    logic [11:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic tbusy;
    logic txd_low;
    logic [11:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rbusy;
    nsf_rx_st_t fst;
    logic [7:0] sum;
    logic [7:0] got;
    logic sep;
    logic empty;
    logic [7:0] odata;
    logic ovalid;
    logic ok;
    logic drop;
  } nsf_link_st_t;

  nsf_link_st_t st_r, st_nxt;
  logic byte_v;
  logic [7:0] ch;
  logic [4:0] hv;

  // ****************************************************************
  // Character timing and sentence check
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovalid = 1'b0;
    st_nxt.ok = 1'b0;
    st_nxt.drop = 1'b0;
    byte_v = 1'b0;
    ch = st_r.rsh;
    hv = nsf_hex_val(st_r.rsh);
    // Start, eight data, stop, no parity
    if (!st_r.tbusy) begin
      if (tx_valid) begin
        st_nxt.tsh = {1'b1, tx_data, 1'b0};
        st_nxt.tbit = FRAME_BITS;
        st_nxt.tcnt = 12'(BIT_PER - 1);
        st_nxt.tbusy = 1'b1;
      end
    end else if (st_r.tcnt == 12'h000) begin
      st_nxt.tcnt = 12'(BIT_PER - 1);
      if (st_r.tbit == 4'h1) begin
        st_nxt.tbusy = 1'b0;
      end else begin
        st_nxt.tsh = {1'b1, st_r.tsh[9:1]};
        st_nxt.tbit = st_r.tbit - 4'h1;
      end
    end else begin
      st_nxt.tcnt = st_r.tcnt - 12'h001;
    end
    st_nxt.txd_low = st_nxt.tbusy & ~st_nxt.tsh[0];
    if (!st_r.rbusy) begin
      if (!rxd) begin
        st_nxt.rbusy = 1'b1;
        st_nxt.rcnt = 12'(BIT_PER / 2 - 1);
        st_nxt.rbit = 4'h0;
      end
    end else if (st_r.rcnt != 12'h000) begin
      st_nxt.rcnt = st_r.rcnt - 12'h001;
    end else begin
      st_nxt.rcnt = 12'(BIT_PER - 1);
      st_nxt.rbit = st_r.rbit + 4'h1;
      if (st_r.rbit == 4'h0) begin
        if (rxd) st_nxt.rbusy = 1'b0;
      end else if (st_r.rbit < STOP_BIT) begin
        st_nxt.rsh = {rxd, st_r.rsh[7:1]};
      end else begin
        st_nxt.rbusy = 1'b0;
        byte_v = rxd;
      end
    end
    if (byte_v) begin
      if (ch == CH_DOLLAR) begin
        st_nxt.drop = (st_r.fst != R_IDLE);
        st_nxt.fst = R_BODY;
        st_nxt.sum = 8'h00;
        st_nxt.sep = 1'b1;
        st_nxt.empty = 1'b0;
      end else begin
        unique case (st_r.fst)
          R_IDLE: st_nxt.fst = R_IDLE;
          R_BODY: begin
            if (ch == CH_STAR) begin
              st_nxt.empty = st_r.empty | (st_r.sep & REJECT_EMPTY);
              st_nxt.fst = R_H1;
            end else if (ch == CH_CR || ch == CH_LF) begin
              st_nxt.fst = R_IDLE;
              st_nxt.drop = 1'b1;
            end else begin
              st_nxt.sum = st_r.sum ^ ch;
              st_nxt.sep = (ch == CH_COMMA);
              if (ch == CH_COMMA && st_r.sep && REJECT_EMPTY) begin
                st_nxt.empty = 1'b1;
              end
              st_nxt.odata = ch;
              st_nxt.ovalid = 1'b1;
            end
          end
          R_H1: begin
            st_nxt.got[7:4] = hv[3:0];
            st_nxt.fst = hv[4] ? R_H0 : R_IDLE;
            st_nxt.drop = ~hv[4];
          end
          R_H0: begin
            st_nxt.got[3:0] = hv[3:0];
            st_nxt.fst = hv[4] ? R_CR : R_IDLE;
            st_nxt.drop = ~hv[4];
          end
          R_CR: begin
            st_nxt.fst = (ch == CH_CR) ? R_LF : R_IDLE;
            st_nxt.drop = (ch != CH_CR);
          end
          R_LF: begin
            st_nxt.fst = R_IDLE;
            if (ch == CH_LF && st_r.got == st_r.sum && !st_r.empty) begin
              st_nxt.ok = 1'b1;
            end else begin
              st_nxt.drop = 1'b1;
            end
          end
          default: st_nxt.fst = R_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_ready = ~st_r.tbusy;
  assign txd = ~st_r.txd_low;
  assign rx_data = st_r.odata;
  assign rx_valid = st_r.ovalid;
  assign rx_ok = st_r.ok;
  assign rx_drop = st_r.drop;

endmodule

// File: rtl/nsf_pkg.sv
// Shared constants, types and helpers for the sentence framer ends
package nsf_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int MSG_RATE_HZ = 1;
  localparam int SEC_CYC = CLK_HZ / MSG_RATE_HZ;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam int SV_PER_MSG = 4;
  localparam logic [6:0] SV_ROUND = 7'(SV_PER_MSG - 1);

  // ****************************************************************
  // Characters and field positions
  // ****************************************************************
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_5 = 8'h35;
  localparam logic [7:0] FIX_NONE = 8'h30;
  localparam logic [3:0] GGA_FIX_FLD = 4'h6;
  localparam logic [3:0] GGA_AGE_FLD = 4'hd;
  localparam logic [2:0] HEAD_LAST = 3'h6;
  localparam logic [15:0] TALK_GP = 16'h4750;
  localparam logic [15:0] TALK_GN = 16'h474e;
  localparam logic [15:0] TALK_GL = 16'h474c;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MSG_GGA = 3'b000, MSG_GLL = 3'b001, MSG_GSA = 3'b010,
    MSG_GSV = 3'b011, MSG_RMC = 3'b100, MSG_VTG = 3'b101,
    MSG_ZDA = 3'b110
  } nsf_msg_t;

  typedef enum logic [1:0] {
    TK_GP = 2'b00, TK_GN = 2'b01, TK_GL = 2'b10
  } nsf_tk_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'b0000, T_HEAD = 4'b0001, T_PAY = 4'b0010,
    T_STAR = 4'b0011, T_HEX1 = 4'b0100, T_HEX0 = 4'b0101,
    T_CR = 4'b0110, T_LF = 4'b0111, T_NEXT = 4'b1000
  } nsf_tx_st_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'b000, R_BODY = 3'b001, R_H1 = 3'b010,
    R_H0 = 3'b011, R_CR = 3'b100, R_LF = 3'b101
  } nsf_rx_st_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] nsf_hex_char(input logic [3:0] v);
    if (v < 4'ha) return 8'h30 + {4'h0, v};
    return 8'h37 + {4'h0, v};
  endfunction

  function automatic logic [4:0] nsf_hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= 8'h30 && c <= 8'h39) d = c - 8'h30;
    else if (c >= 8'h41 && c <= 8'h46) d = c - 8'h37;
    else if (c >= 8'h61 && c <= 8'h66) d = c - 8'h57;
    else return 5'h00;
    return {1'b1, d[3:0]};
  endfunction

  function automatic logic [23:0] nsf_msg_id(input nsf_msg_t m);
    unique case (m)
      MSG_GGA: return 24'h474741;
      MSG_GLL: return 24'h474c4c;
      MSG_GSA: return 24'h475341;
      MSG_GSV: return 24'h475356;
      MSG_RMC: return 24'h524d43;
      MSG_VTG: return 24'h565447;
      default: return 24'h5a4441;
    endcase
  endfunction

endpackage

// File: tb/nmea_sentence_serial_framer_tb.sv
// Bench joining the receiver end and the host end
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  failures++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module nmea_sentence_serial_framer_tb import nsf_pkg::*; ();
  localparam int BP = 16;
  localparam int HB = BP / 2;
  localparam int WD = 300 * 10 * BP;
  logic clk, nrst, combined, fix3d, dgps_used, zda_on, zda_off, pl_gl;
  logic [5:0] gp_sv_cnt, gl_sv_cnt;
  logic [7:0] pl_data, in_data, cmd_data, out_data, rnd, d;
  logic pl_valid, pl_last, pl_ready, in_valid, in_ok, in_drop;
  logic cmd_valid, cmd_last, cmd_ready, out_valid, out_ok, out_drop;
  logic [2:0] pl_msg;
  logic [4:0] pl_part;
  logic [7:0] gpl[$], body[$], ex[$], got[$];
  int failures, n_compared, n_out_ok, n_out_drop, f, n_exp;
  string cs;
  nsf_if lnk();
  nsf_device #(.SEC_PER(WD * 2), .BIT_PER(BP)) nsf_device_i (
    .clk(clk), .nrst(nrst),
    .lnk(lnk), .combined(combined), .fix3d(fix3d), .dgps_used(dgps_used),
    .gp_sv_cnt(gp_sv_cnt), .gl_sv_cnt(gl_sv_cnt), .zda_on(zda_on),
    .zda_off(zda_off), .pl_msg(pl_msg), .pl_part(pl_part), .pl_gl(pl_gl),
    .pl_data(pl_data), .pl_valid(pl_valid), .pl_last(pl_last),
    .pl_ready(pl_ready), .in_data(in_data), .in_valid(in_valid),
    .in_ok(in_ok), .in_drop(in_drop));
  nsf_host #(.BIT_PER(BP)) nsf_host_i (.clk(clk), .nrst(nrst), .lnk(lnk),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ok(out_ok), .out_drop(out_drop));
  nsf_checker #(.BIT_PER(BP)) nsf_checker_i (.clk(clk), .nrst(nrst),
    .dev_txd(lnk.dev_txd), .host_txd(lnk.host_txd));
  // ********************
  // Helpers
  // ********************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  function automatic int n_parts(input int n);
    return (n == 0) ? 1 : (n + SV_PER_MSG - 1) / SV_PER_MSG;
  endfunction
  task automatic add(input string s);
    for (int i = 0; i < s.len(); i++) body.push_back(s[i]);
  endtask
  task automatic frame();
    logic [7:0] x;
    x = 8'h00;
    foreach (body[i]) x ^= body[i];
    ex = {CH_DOLLAR, body, CH_STAR, hexc(x[7:4]), hexc(x[3:0]), CH_CR, CH_LF};
  endtask
  task automatic expect_line();
    logic [7:0] c;
    foreach (ex[n]) begin
      @(negedge lnk.dev_txd);
      repeat (HB) @(negedge clk);
      `CHK("start bit", 1'b0, lnk.dev_txd)
      for (int i = 0; i < 8; i++) begin
        repeat (BP) @(negedge clk);
        c[i] = lnk.dev_txd;
      end
      repeat (BP) @(negedge clk);
      `CHK("stop bit", 1'b1, lnk.dev_txd)
      `CHK("char", ex[n], c)
    end
  endtask
  task automatic send_cmd(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      cmd_data = s[i];
      cmd_valid = 1'b1;
      cmd_last = (i == s.len() - 1);
      #1;
      while (cmd_ready !== 1'b1) begin
        @(negedge clk);
        #1;
      end
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic verdict(input logic ok);
    int n;
    n = 0;
    while (in_ok !== 1'b1 && in_drop !== 1'b1 && n < WD) begin
      @(negedge clk);
      n++;
    end
    `CHK("input verdict", {ok, !ok}, {in_ok, in_drop})
  endtask
  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ********************
  // Processes
  // ********************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (WD) @(posedge clk);
    failures++;
    end_of_test();
  end
  always @(negedge clk) begin
    if (in_valid === 1'b1) got.push_back(in_data);
    if (out_ok === 1'b1) n_out_ok++;
    if (out_drop === 1'b1) n_out_drop++;
  end
  initial begin : feed
    int k;
    logic go;
    k = 0;
    go = 1'b0;
    pl_valid = 1'b0;
    pl_data = 8'h00;
    pl_last = 1'b0;
    forever begin
      @(negedge clk);
      if (go) k = pl_last ? 0 : k + 1;
      pl_valid = nrst;
      pl_data = (pl_msg == MSG_GGA) ? gpl[k] : 8'h31;
      pl_last = (pl_msg != MSG_GGA) || (k == gpl.size() - 1);
      #1 go = pl_valid && pl_ready;
    end
  end
  initial begin
    nrst = 1'b0;
    rnd = 8'h50;
    combined = 1'b1;
    dgps_used = 1'b0;
    zda_on = 1'b0;
    zda_off = 1'b0;
    fix3d = rnd[4];
    gp_sv_cnt = rnd[5:0];
    gl_sv_cnt = rnd[7:2];
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    failures = 0;
    n_compared = 0;
    n_out_ok = 0;
    n_out_drop = 0;
    for (int i = 1; i <= 14; i++) begin
      if (i > 1) gpl.push_back(CH_COMMA);
      rnd = lfsr(rnd);
      d = 8'h30 + rnd % 8'd10;
      if (i == 6) d = CH_3 + rnd % 8'd3;
      if (i == 10 || i == 12) d = 8'h4d;
      gpl.push_back(d);
    end
    f = 1;
    add("GPGGA,");
    foreach (gpl[i]) begin
      d = gpl[i];
      if (d == CH_COMMA) f++;
      else if (f == 13) continue;
      else if (f == 6 && d >= CH_3 && d <= CH_5) d = FIX_NONE;
      body.push_back(d);
    end
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    fork
      begin
        frame();
        expect_line();
        body.delete();
        add("GNGLL,1");
        frame();
        expect_line();
        repeat (BP) @(negedge clk);
        `CHK("sentences taken", 2, n_out_ok)
        `CHK("sentences refused", 0, n_out_drop)
        n_exp = 5 + n_parts(gp_sv_cnt) + (combined ? n_parts(gl_sv_cnt) : 0);
        while (n_out_ok < n_exp) @(negedge clk);
        repeat (15 * 10 * BP) @(negedge clk);
        `CHK("burst sentences", n_exp, n_out_ok)
        `CHK("burst refused", 0, n_out_drop)
      end
      begin
        cs = "PX,12";
        send_cmd(cs);
        verdict(1'b1);
        `CHK("input length", cs.len(), got.size())
        foreach (got[i]) `CHK("input char", cs[i], got[i])
        send_cmd("PX,,1");
        verdict(1'b0);
      end
    join
    end_of_test();
  end
endmodule

// File: tb/nsf_checker.sv
// Serial line framing checks for both framer ends
`timescale 1ns/1ps
module nsf_checker import nsf_pkg::*; #(
  parameter int BIT_PER = BIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dev_txd,
  input wire logic host_txd
);
  localparam int HALF = BIT_PER / 2;
  localparam int STOP_AT = 9 * BIT_PER + HALF;
  localparam int LAST = 10 * BIT_PER - 1;
  logic dp_r;
  logic hp_r;
  logic [15:0] dfc_r;
  logic [15:0] hfc_r;
  logic [15:0] dlo_r;
  logic [15:0] hlo_r;
  // ********************
  // Frame and run counters
  // ********************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_r <= 1'b1;
      hp_r <= 1'b1;
      dfc_r <= 16'h0000;
      hfc_r <= 16'h0000;
      dlo_r <= 16'h0000;
      hlo_r <= 16'h0000;
    end else begin
      dp_r <= dev_txd;
      hp_r <= host_txd;
      dlo_r <= dev_txd ? 16'h0000 : dlo_r + 16'h0001;
      hlo_r <= host_txd ? 16'h0000 : hlo_r + 16'h0001;
      if (dfc_r != 16'h0000)
        dfc_r <= (dfc_r == 16'(LAST)) ? 16'h0000 : dfc_r + 16'h0001;
      else if (dp_r && !dev_txd)
        dfc_r <= 16'h0001;
      if (hfc_r != 16'h0000)
        hfc_r <= (hfc_r == 16'(LAST)) ? 16'h0000 : hfc_r + 16'h0001;
      else if (hp_r && !host_txd)
        hfc_r <= 16'h0001;
    end
  end
  // ********************
  // Assertions
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_dev_idle; $rose(nrst) |-> dev_txd; endproperty
  a_dev_idle: assert property (p_dev_idle)
    else $error("device line not idle after reset");
  property p_host_idle; $rose(nrst) |-> host_txd; endproperty
  a_host_idle: assert property (p_host_idle)
    else $error("host line not idle after reset");
  property p_dev_start; dfc_r == 16'(HALF) |-> !dev_txd; endproperty
  a_dev_start: assert property (p_dev_start)
    else $error("device start bit short");
  property p_host_start;
    $fell(host_txd) && hfc_r == 16'h0000 |=> !host_txd [*8];
  endproperty
  a_host_start: assert property (p_host_start)
    else $error("host start bit glitch");
  property p_dev_stop; dfc_r == 16'(STOP_AT) |-> dev_txd; endproperty
  a_dev_stop: assert property (p_dev_stop)
    else $error("device stop bit missing");
  property p_host_stop; hfc_r == 16'(STOP_AT) |-> host_txd; endproperty
  a_host_stop: assert property (p_host_stop)
    else $error("host stop bit missing");
  property p_dev_low;
    $rose(dev_txd) |-> dlo_r % 16'(BIT_PER) == 16'h0000 &&
      dlo_r != 16'h0000 && dlo_r <= 16'(9 * BIT_PER);
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device low run not whole bits");
  property p_host_low;
    $rose(host_txd) |-> hlo_r % 16'(BIT_PER) == 16'h0000 &&
      hlo_r != 16'h0000 && hlo_r <= 16'(9 * BIT_PER);
  endproperty
  a_host_low: assert property (p_host_low)
    else $error("host low run not whole bits");
endmodule
